// File: hdl/acmt_host.sv
// Strobed register access was decided locally.
`default_nettype none
module acmt_host (
	// Clock and reset
	input wire logic clk,
	input wire logic rstn,
	// Link to sensor
	acmt_if.host lnk,
	// Software register port
	input wire logic [3:0] reg_addr,
	input wire logic [15:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [15:0] reg_rdata,
	// Motor controller side
	output logic [2:0] uvw_o
);
	import acmt_pkg::*;

	// ------------------------------------------------
	// State
	// ------------------------------------------------
	acmt_st_e st_q;
	acmt_op_e op_q;
	logic [1:0] step_q;
	logic [3:0] tmo_q;
	logic man_q, done_q, tout_q;
	logic [8:0] haddr_q;
	logic [15:0] hwd_q, exa_q, exh_q, exl_q;
	logic [15:0] rd_q, rdh_q, rdl_q, rdata_q;
	logic [7:0] laddr_q;
	logic lwr_q;
	logic [15:0] lwd_q;
	logic [2:0] uvw_q;

	// ------------------------------------------------
	// Step table
	// ------------------------------------------------
	wire go = reg_wr & (reg_addr == H_GO) & (st_q == ST_IDLE);
	acmt_op_e op_n;
	assign op_n = go ? acmt_op_e'(reg_wdata[1:0]) : op_q;
	logic [1:0] step_n;
	logic [7:0] s_addr;
	logic s_wr;
	logic [15:0] s_data;
	wire last = (op_q == OP_ONE || op_q == OP_TRST) ?
		1'b1 : (step_q == 2'h3);

	always_comb begin
		s_addr = haddr_q[7:0];
		s_wr = haddr_q[8];
		s_data = hwd_q;
		case ({op_n, step_n})
			{OP_TRST, 2'h0}: begin
				s_addr = A_CTRL;
				s_wr = 1'b1;
				s_data = {12'h000, CMD_TURN_RST};
			end
			{OP_EXW, 2'h0}: begin
				s_addr = A_XWADR;
				s_wr = 1'b1;
				s_data = exa_q;
			end
			{OP_EXW, 2'h1}: begin
				s_addr = A_XWHI;
				s_wr = 1'b1;
				s_data = exh_q;
			end
			{OP_EXW, 2'h2}: begin
				s_addr = A_XWLO;
				s_wr = 1'b1;
				s_data = exl_q;
			end
			{OP_EXW, 2'h3}: begin
				s_addr = A_XWCMD;
				s_wr = 1'b1;
				s_data = CMD_GO;
			end
			{OP_EXR, 2'h0}: begin
				s_addr = A_XRADR;
				s_wr = 1'b1;
				s_data = exa_q;
			end
			{OP_EXR, 2'h1}: begin
				s_addr = A_XRCMD;
				s_wr = 1'b1;
				s_data = CMD_GO;
			end
			{OP_EXR, 2'h2}: begin
				s_addr = A_XRHI;
				s_wr = 1'b0;
			end
			{OP_EXR, 2'h3}: begin
				s_addr = A_XRLO;
				s_wr = 1'b0;
			end
			default: begin
				s_addr = haddr_q[7:0];
			end
		endcase
	end
	assign step_n = go ? 2'h0 : step_q + 2'h1;
	wire load = go | (st_q == ST_WAIT & lnk.ack & ~last);

	// ------------------------------------------------
	// Sequencer
	// ------------------------------------------------
	// Timeout covers a sensor that ignores Manchester
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			st_q <= ST_IDLE;
			op_q <= OP_ONE;
			step_q <= 2'h0;
			tmo_q <= 4'h0;
			done_q <= 1'b0;
			tout_q <= 1'b0;
		end else begin
			op_q <= op_n;
			if (load) begin
				step_q <= step_n;
			end
			if (go) begin
				done_q <= 1'b0;
				tout_q <= 1'b0;
			end
			case (st_q)
				ST_IDLE: begin
					if (go) begin
						st_q <= ST_SEND;
					end
				end
				ST_SEND: begin
					st_q <= ST_WAIT;
					tmo_q <= 4'h0;
				end
				ST_WAIT: begin
					tmo_q <= tmo_q + 4'h1;
					if (lnk.ack) begin
						st_q <= last ? ST_IDLE : ST_SEND;
						done_q <= last;
					end else if (tmo_q == TIMEOUT_CYC) begin
						st_q <= ST_IDLE;
						tout_q <= 1'b1;
					end
				end
				default: begin
					st_q <= ST_IDLE;
				end
			endcase
		end
	end

	// ------------------------------------------------
	// Registers and link drive
	// ------------------------------------------------
	wire cap = (st_q == ST_WAIT) & lnk.ack & ~lwr_q;
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			man_q <= 1'b0;
			haddr_q <= 9'h000;
			hwd_q <= 16'h0000;
			exa_q <= 16'h0000;
			exh_q <= 16'h0000;
			exl_q <= 16'h0000;
			rd_q <= 16'h0000;
			rdh_q <= 16'h0000;
			rdl_q <= 16'h0000;
			laddr_q <= 8'h00;
			lwr_q <= 1'b0;
			lwd_q <= 16'h0000;
		end else begin
			if (reg_wr && reg_addr == H_CFG) begin
				man_q <= reg_wdata[0];
			end
			if (reg_wr && reg_addr == H_ADDR) begin
				haddr_q <= reg_wdata[8:0];
			end
			if (reg_wr && reg_addr == H_WDATA) begin
				hwd_q <= reg_wdata;
			end
			if (reg_wr && reg_addr == H_EXA) begin
				exa_q <= reg_wdata;
			end
			if (reg_wr && reg_addr == H_EXH) begin
				exh_q <= reg_wdata;
			end
			if (reg_wr && reg_addr == H_EXL) begin
				exl_q <= reg_wdata;
			end
			if (load) begin
				laddr_q <= s_addr;
				lwr_q <= s_wr;
				lwd_q <= s_data;
			end
			if (cap && op_q == OP_ONE) begin
				rd_q <= lnk.rdata;
			end
			if (cap && op_q == OP_EXR && step_q == 2'h2) begin
				rdh_q <= lnk.rdata;
			end
			if (cap && op_q == OP_EXR && step_q == 2'h3) begin
				rdl_q <= lnk.rdata;
			end
		end
	end

	wire [15:0] rmux =
		(reg_addr == H_CFG) ? {15'h0000, man_q} :
		(reg_addr == H_ADDR) ? {7'h00, haddr_q} :
		(reg_addr == H_WDATA) ? hwd_q :
		(reg_addr == H_EXA) ? exa_q :
		(reg_addr == H_EXH) ? exh_q :
		(reg_addr == H_EXL) ? exl_q :
		(reg_addr == H_STAT) ? {13'h0000, st_q != ST_IDLE,
			tout_q, done_q} :
		(reg_addr == H_RDATA) ? rd_q :
		(reg_addr == H_RDH) ? rdh_q :
		(reg_addr == H_RDL) ? rdl_q :
		16'h0000;

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			rdata_q <= 16'h0000;
			uvw_q <= 3'h0;
		end else begin
			rdata_q <= reg_rd ? rmux : 16'h0000;
			uvw_q <= lnk.commutation_outputs;
		end
	end

	assign lnk.man = man_q;
	assign lnk.req = (st_q == ST_SEND);
	assign lnk.wr = lwr_q;
	assign lnk.addr = laddr_q;
	assign lnk.wdata = lwd_q;
	assign reg_rdata = rdata_q;
	assign uvw_o = uvw_q;
endmodule
`default_nettype wire

// File: hdl/acmt_pkg.sv
// Functional notes
// - Route enable picks filtered angle for commutation
// - Outputs toggle when angle crosses transition
// - Default: half-cycle high, 120 degree spacing
// - Pole-pair code plus one repeats pattern
// - Window width is field times 14-bit step
// - Filtered angle readable at 12-bit resolution
// - Same direction: output follows sensor instantly
// - Reversal holds output inside window
// - Opposite exit flips reference direction
// - Direction bit: 0 increasing, 1 decreasing
// - Reset and self-test: increasing, window behind
// - Turns step 45 or 180 degrees, own path
// - Turns counter saturates at mode limits
// - Saturation sets sticky warning until turns reset
// - Host resets turns via control command
// - Manchester disable ignores Manchester commands
// - Lock rejects writes on both links
// - Extended write: address, halves, then command
// - Extended read: address, command, data halves
// - All fields reachable through primary registers
// - Manchester commands in, answers on output
`default_nettype none
package acmt_pkg;
	// ------------------------------------------------
	// Primary register byte addresses
	// ------------------------------------------------
	localparam logic [7:0] A_XWADR = 8'h02;
	localparam logic [7:0] A_XWHI = 8'h04;
	localparam logic [7:0] A_XWLO = 8'h06;
	localparam logic [7:0] A_XWCMD = 8'h08;
	localparam logic [7:0] A_XRADR = 8'h0a;
	localparam logic [7:0] A_XRCMD = 8'h0c;
	localparam logic [7:0] A_XRHI = 8'h0e;
	localparam logic [7:0] A_XRLO = 8'h10;
	localparam logic [7:0] A_CTRL = 8'h1e;
	localparam logic [7:0] A_ANGLE = 8'h20;
	localparam logic [7:0] A_STAT = 8'h22;
	localparam logic [7:0] A_HANG = 8'h24;
	localparam logic [7:0] A_WARN = 8'h26;
	localparam logic [7:0] A_TURNS = 8'h28;
	// ------------------------------------------------
	// Extended locations and fields
	// ------------------------------------------------
	localparam logic [5:0] X_HYS = 6'h17;
	localparam logic [5:0] X_CFG = 6'h19;
	localparam logic [5:0] X_OPT = 6'h1b;
	localparam int CFG_ROUTE_BIT = 12;
	localparam int CFG_PP_LSB = 0;
	localparam int HYS_LSB = 12;
	localparam int OPT_MDIS_BIT = 2;
	localparam int OPT_STEP45_BIT = 3;
	localparam int GO_BIT = 0;
	localparam int DONE_BIT = 15;
	localparam logic [15:0] CMD_GO = 16'h0001;
	localparam logic [3:0] CMD_TURN_RST = 4'h1;
	localparam logic [31:0] X_RST = 32'h0000_0000;
	// ------------------------------------------------
	// Commutation and turns constants
	// ------------------------------------------------
	localparam logic [13:0] PH_OFF [3] = '{14'h0000, 14'h1555,
		14'h2aab};
	localparam logic [11:0] LIM45_HI = 12'h7ff;
	localparam logic [11:0] LIM45_LO = 12'h800;
	localparam logic [11:0] LIM180_HI = 12'h1ff;
	localparam logic [11:0] LIM180_LO = 12'he00;
	// ------------------------------------------------
	// Host controller registers and sequencer
	// ------------------------------------------------
	localparam logic [3:0] H_CFG = 4'h0;
	localparam logic [3:0] H_ADDR = 4'h1;
	localparam logic [3:0] H_WDATA = 4'h2;
	localparam logic [3:0] H_EXA = 4'h3;
	localparam logic [3:0] H_EXH = 4'h4;
	localparam logic [3:0] H_EXL = 4'h5;
	localparam logic [3:0] H_GO = 4'h6;
	localparam logic [3:0] H_STAT = 4'h7;
	localparam logic [3:0] H_RDATA = 4'h8;
	localparam logic [3:0] H_RDH = 4'h9;
	localparam logic [3:0] H_RDL = 4'ha;
	localparam logic [3:0] TIMEOUT_CYC = 4'h8;
	typedef enum logic [1:0] {
		OP_ONE = 2'b00,
		OP_TRST = 2'b01,
		OP_EXW = 2'b10,
		OP_EXR = 2'b11
	} acmt_op_e;
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_SEND = 2'b01,
		ST_WAIT = 2'b10
	} acmt_st_e;
endpackage
`default_nettype wire

// File: hdl/acmt_if.sv
`default_nettype none
interface acmt_if;
	logic req;
	logic wr;
	logic man;
	logic [7:0] addr;
	logic [15:0] wdata;
	logic ack;
	logic [15:0] rdata;
	logic [2:0] commutation_outputs;
	modport dev(input req, wr, man, addr, wdata,
		output ack, rdata, commutation_outputs);
	modport host(output req, wr, man, addr, wdata,
		input ack, rdata, commutation_outputs);
endinterface
`default_nettype wire

// File: hdl/acmt_dev.sv
`default_nettype none
module acmt_dev (
	// Clock and reset
	input wire logic clk,
	input wire logic rstn,
	// Link to host and motor controller
	acmt_if.dev lnk,
	// Sensor side
	input wire logic [13:0] angle_i,
	input wire logic [2:0] turn_oct_i,
	input wire logic lock_i,
	input wire logic selftest_i
);
	import acmt_pkg::*;

	// ------------------------------------------------
	// State
	// ------------------------------------------------
	logic [15:0] xwadr_q, xwhi_q, xwlo_q, xwcmd_q;
	logic [15:0] xradr_q, xrcmd_q, xrhi_q, xrlo_q, ctrl_q;
	logic [31:0] xmem_q [0:63];
	logic ack_q;
	logic [15:0] rdata_q;
	logic [2:0] uvw_q;
	logic [13:0] hys_q;
	logic dir_q, init_q;
	logic [2:0] oct_q;
	logic [11:0] trn_q;
	logic warn_q;

	// ------------------------------------------------
	// Configuration from extended locations
	// ------------------------------------------------
	wire route = xmem_q[X_CFG][CFG_ROUTE_BIT];
	wire [3:0] pp = xmem_q[X_CFG][CFG_PP_LSB +: 4];
	wire [5:0] hw = xmem_q[X_HYS][HYS_LSB +: 6];
	wire mdis = xmem_q[X_OPT][OPT_MDIS_BIT];
	wire step45 = xmem_q[X_OPT][OPT_STEP45_BIT];

	// ------------------------------------------------
	// Access decode
	// ------------------------------------------------
	// Manchester requests dropped while mdis is set
	wire take = lnk.req & ~(lnk.man & mdis);
	wire wr_ok = take & lnk.wr & ~lock_i;
	wire [7:0] a = lnk.addr;
	wire [15:0] wd = lnk.wdata;
	wire xw_go = wr_ok & (a == A_XWCMD) & wd[GO_BIT];
	wire xr_go = wr_ok & (a == A_XRCMD) & wd[GO_BIT];
	wire trst = wr_ok & (a == A_CTRL) & (wd[3:0] == CMD_TURN_RST);

	// ------------------------------------------------
	// Hysteresis
	// ------------------------------------------------
	wire [13:0] dif = angle_i - hys_q;
	wire neg = dif[13];
	wire [13:0] mag = neg ? 14'h0000 - dif : dif;
	wire outw = mag > {8'h00, hw};
	wire adv = dir_q ? neg : (~neg & (dif != 14'h0000));
	// exit on far side flips head
	wire rev = (dir_q ? ~neg : neg) & outw;
	wire reinit = init_q | selftest_i;
	wire [13:0] hys_out = (adv | rev | reinit) ? angle_i : hys_q;

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			hys_q <= 14'h0000;
			dir_q <= 1'b0;
			init_q <= 1'b1;
		end else begin
			hys_q <= hys_out;
			dir_q <= reinit ? 1'b0 : dir_q ^ rev;
			init_q <= 1'b0;
		end
	end

	// ------------------------------------------------
	// Commutation
	// ------------------------------------------------
	// filtered angle when routed
	wire [13:0] src = route ? hys_out : angle_i;
	wire [18:0] prod = src * ({1'b0, pp} + 5'h01);
	wire [13:0] elec = prod[13:0];
	wire [2:0] uvw_d;
	genvar gi;
	generate
		for (gi = 0; gi < 3; gi++) begin : g_ph
			wire [13:0] ph = elec - PH_OFF[gi];
			assign uvw_d[gi] = ~ph[13];
		end
	endgenerate

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			uvw_q <= 3'h0;
		end else begin
			uvw_q <= uvw_d;
		end
	end

	// ------------------------------------------------
	// Turns counter
	// ------------------------------------------------
	wire [2:0] od = turn_oct_i - oct_q;
	wire up = (od == 3'h1) & (step45 | (turn_oct_i[1:0] == 2'b00));
	wire dn = (od == 3'h7) & (step45 | (oct_q[1:0] == 2'b00));
	wire [11:0] hi = step45 ? LIM45_HI : LIM180_HI;
	wire [11:0] lo = step45 ? LIM45_LO : LIM180_LO;
	wire sat_hi = $signed(trn_q) >= $signed(hi);
	wire sat_lo = $signed(trn_q) <= $signed(lo);
	wire sat = ~init_q & ((up & sat_hi) | (dn & sat_lo));

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			oct_q <= 3'h0;
			trn_q <= 12'h000;
			warn_q <= 1'b0;
		end else begin
			oct_q <= turn_oct_i;
			warn_q <= sat | (warn_q & ~trst);
			if (trst) begin
				trn_q <= 12'h000;
			end else if (!init_q && up && !sat) begin
				trn_q <= trn_q + 12'h001;
			end else if (!init_q && dn && !sat) begin
				trn_q <= trn_q - 12'h001;
			end
		end
	end

	// ------------------------------------------------
	// Primary registers
	// ------------------------------------------------
	// everything through primary set
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			xwadr_q <= 16'h0000;
			xwhi_q <= 16'h0000;
			xwlo_q <= 16'h0000;
			xwcmd_q <= 16'h0000;
			xradr_q <= 16'h0000;
			xrcmd_q <= 16'h0000;
			xrhi_q <= 16'h0000;
			xrlo_q <= 16'h0000;
			ctrl_q <= 16'h0000;
		end else begin
			if (wr_ok && a == A_XWADR) begin
				xwadr_q <= wd;
			end
			if (wr_ok && a == A_XWHI) begin
				xwhi_q <= wd;
			end
			if (wr_ok && a == A_XWLO) begin
				xwlo_q <= wd;
			end
			if (wr_ok && a == A_XRADR) begin
				xradr_q <= wd;
			end
			// Command field self-clears
			if (wr_ok && a == A_CTRL) begin
				ctrl_q <= {wd[15:4], 4'h0};
			end
			if (wr_ok && a == A_XWCMD) begin
				xwcmd_q <= {xw_go, wd[14:0]};
			end
			if (wr_ok && a == A_XRCMD) begin
				xrcmd_q <= {xr_go, wd[14:0]};
			end
			if (xr_go) begin
				xrhi_q <= xmem_q[xradr_q[5:0]][31:16];
				xrlo_q <= xmem_q[xradr_q[5:0]][15:0];
			end
		end
	end

	// Upper address bits ignored: 64 locations
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			for (int i = 0; i < 64; i++) begin
				xmem_q[i] <= X_RST;
			end
		end else if (xw_go) begin
			xmem_q[xwadr_q[5:0]] <= {xwhi_q, xwlo_q};
		end
	end

	// ------------------------------------------------
	// Read mux and answer
	// ------------------------------------------------
	wire [15:0] rmux =
		(a == A_XWADR) ? xwadr_q :
		(a == A_XWHI) ? xwhi_q :
		(a == A_XWLO) ? xwlo_q :
		(a == A_XWCMD) ? xwcmd_q :
		(a == A_XRADR) ? xradr_q :
		(a == A_XRCMD) ? xrcmd_q :
		(a == A_XRHI) ? xrhi_q :
		(a == A_XRLO) ? xrlo_q :
		(a == A_CTRL) ? ctrl_q :
		(a == A_ANGLE) ? {2'b00, angle_i} :
		(a == A_STAT) ? {15'h0000, dir_q} :
		(a == A_HANG) ? {4'h0, hys_out[13:2]} :
		(a == A_WARN) ? {15'h0000, warn_q} :
		(a == A_TURNS) ? {{4{trn_q[11]}}, trn_q} :
		16'h0000;

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			ack_q <= 1'b0;
			rdata_q <= 16'h0000;
		end else begin
			ack_q <= take;
			if (take) begin
				rdata_q <= rmux;
			end
		end
	end

	assign lnk.ack = ack_q;
	assign lnk.rdata = rdata_q;
	assign lnk.commutation_outputs = uvw_q;
endmodule
`default_nettype wire

// File: verif/acmt_chk.sv
`default_nettype none
module acmt_chk (
	// Clock and reset
	input wire logic clk,
	input wire logic rstn,
	// Link signals
	input wire logic req,
	input wire logic wr,
	input wire logic man,
	input wire logic [7:0] addr,
	input wire logic [15:0] wdata,
	input wire logic ack,
	input wire logic [15:0] rdata,
	input wire logic [2:0] commutation_outputs
);
	import acmt_pkg::*;
	// ------------------------------
	// Link checks
	// ------------------------------
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rstn);
	logic [1:0] up_q;
	// Hall-state check skipped for three edges after reset
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			up_q <= 2'h0;
		end else if (up_q != 2'h3) begin
			up_q <= up_q + 2'h1;
		end
	end
	sequence s_wr(logic [7:0] a);
		req && wr && addr == a ##1 ack;
	endsequence
	sequence s_rd(logic [7:0] a);
		req && !wr && addr == a;
	endsequence
	AST_ACK_AFTER_REQ: assert property (req && !man |=> ack)
		else $error("request not answered");
	AST_ACK_PULSE: assert property (ack |=> !ack)
		else $error("answer longer than one cycle");
	AST_ACK_CAUSE: assert property (ack |-> $past(req))
		else $error("answer without request");
	AST_REQ_GAP: assert property (req |=> !req)
		else $error("requests too close");
	AST_EXT_WRITE: assert property (s_wr(A_XWLO) |=>
		req && wr && addr == A_XWCMD && wdata == CMD_GO)
		else $error("extended write command missing");
	AST_EXT_READ: assert property (s_wr(A_XRCMD) |=>
		s_rd(A_XRHI) ##2 s_rd(A_XRLO))
		else $error("extended read halves missing");
	AST_HALL_STATE: assert property (up_q == 2'h3 |->
		commutation_outputs != 3'h0 && commutation_outputs != 3'h7)
		else $error("commutation state illegal");
	AST_RDATA_HOLD: assert property (!ack |-> $stable(rdata))
		else $error("read data moved without answer");
endmodule
`default_nettype wire

// File: verif/angle_commutation_turns_backend_test.sv
`default_nettype none
module angle_commutation_turns_backend_test;
	timeunit 1ns;
	timeprecision 1ns;
	import acmt_pkg::*;
	// ------------------------------
	// Bench
	// ------------------------------
	logic clk = 1'b0;
	logic rstn = 1'b0;
	logic [3:0] reg_addr = 4'h0;
	logic [15:0] reg_wdata = 16'h0000;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [15:0] reg_rdata;
	logic [2:0] uvw_o;
	logic [13:0] angle_i = 14'h0800;
	logic [2:0] turn_oct_i = 3'h0;
	logic lock_i = 1'b0;
	logic selftest_i = 1'b0;
	int mismatches = 0;
	int checks = 0;
	int seed = 69;
	int cs [5] = '{5, 1, -6, -1, 12};
	logic [15:0] rv;
	logic [31:0] xv;
	logic [31:0] xo;
	logic [13:0] held;
	logic dir;
	logic [11:0] tc;
	logic tw;
	logic step45;
	acmt_if lnk();
	acmt_dev i_acmt_dev (.clk(clk), .rstn(rstn), .lnk(lnk), .angle_i(angle_i),
		.turn_oct_i(turn_oct_i), .lock_i(lock_i), .selftest_i(selftest_i));
	acmt_host i_acmt_host (.clk(clk), .rstn(rstn), .lnk(lnk),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_rdata(reg_rdata), .uvw_o(uvw_o));
	acmt_chk i_acmt_chk (.clk(clk), .rstn(rstn), .req(lnk.req), .wr(lnk.wr),
		.man(lnk.man), .addr(lnk.addr), .wdata(lnk.wdata), .ack(lnk.ack),
		.rdata(lnk.rdata), .commutation_outputs(lnk.commutation_outputs));
	initial begin
		forever #50 clk = ~clk;
	end
	task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			mismatches++;
			$display("[FAIL] %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic results();
		if (mismatches == 0 && checks > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask
	task automatic cyc(int n);
		repeat (n) @(posedge clk);
	endtask
	// Extra idle cycle keeps each strobe to one assignment per step
	task automatic wreg(logic [3:0] a, logic [15:0] d);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		cyc(1);
		reg_wr <= 1'b0;
		cyc(1);
	endtask
	task automatic rreg(logic [3:0] a, output logic [15:0] d);
		reg_addr <= a;
		reg_rd <= 1'b1;
		cyc(1);
		reg_rd <= 1'b0;
		cyc(1);
		d = reg_rdata;
	endtask
	task automatic go(logic [1:0] op);
		wreg(H_GO, {14'h0, op});
		for (int i = 0; i < 60; i++) begin
			rreg(H_STAT, rv);
			if (rv[2] === 1'b0) break;
		end
		if (rv[2] !== 1'b0) begin
			mismatches++;
			results();
		end
	endtask
	task automatic drd(logic [7:0] a, output logic [15:0] d);
		wreg(H_ADDR, {8'h0, a});
		go(2'h0);
		rreg(H_RDATA, d);
	endtask
	task automatic xwr(logic [5:0] a, logic [31:0] d);
		wreg(H_EXA, {10'h0, a});
		wreg(H_EXH, d[31:16]);
		wreg(H_EXL, d[15:0]);
		go(2'h2);
	endtask
	task automatic xrd(logic [5:0] a, output logic [31:0] d);
		wreg(H_EXA, {10'h0, a});
		go(2'h3);
		rreg(H_RDH, d[31:16]);
		rreg(H_RDL, d[15:0]);
	endtask
	function automatic logic [2:0] phase_of(logic [13:0] a, logic [3:0] p);
		logic [13:0] e;
		e = 14'(a * (p + 14'h1));
		phase_of[0] = e < 14'h2000;
		phase_of[1] = 14'(e - PH_OFF[1]) < 14'h2000;
		phase_of[2] = 14'(e - PH_OFF[2]) < 14'h2000;
	endfunction
	task automatic hstep(logic [13:0] a);
		logic signed [13:0] df;
		angle_i <= a;
		cyc(3);
		df = a - held;
		if (dir ? df < 0 : df > 0) begin
			held = a;
		end else if ((dir ? df : -df) > 14'sd10) begin
			held = a;
			dir = !dir;
		end
		drd(A_HANG, rv);
		check("filtered", rv, {4'h0, held[13:2]});
		drd(A_STAT, rv);
		check("direction", rv[0], dir);
		check("routed", uvw_o, phase_of(held, 4'h0));
	endtask
	task automatic selftest();
		selftest_i <= 1'b1;
		cyc(1);
		selftest_i <= 1'b0;
		cyc(2);
		held = angle_i;
		dir = 1'b0;
	endtask
	task automatic omove(int n, bit up);
		logic [2:0] nx;
		logic [11:0] lim;
		repeat (n) begin
			nx = turn_oct_i + (up ? 3'h1 : 3'h7);
			lim = up ? (step45 ? LIM45_HI : LIM180_HI) :
				(step45 ? LIM45_LO : LIM180_LO);
			if (step45 || (up ? nx[1:0] : turn_oct_i[1:0]) == 2'h0) begin
				if (tc == lim) tw = 1'b1;
				else tc = tc + (up ? 12'h1 : 12'hfff);
			end
			turn_oct_i <= nx;
			cyc(1);
		end
		drd(A_TURNS, rv);
		check("turns", rv, {{4{tc[11]}}, tc});
		drd(A_WARN, rv);
		check("turn flag", rv[0], tw);
	endtask
	initial begin
		cyc(4);
		rstn <= 1'b1;
		cyc(1);
		xrd(X_CFG, xv);
		check("ext reset", xv, X_RST);
		drd(8'h40, rv);
		check("unmapped dev", rv, 16'h0000);
		rreg(4'hf, rv);
		check("unmapped host", rv, 16'h0000);
		xo = $random(seed);
		xwr(X_HYS, xo);
		xrd(X_HYS, xv);
		check("ext roundtrip", xv, xo);
		angle_i <= 14'($random(seed));
		drd(A_ANGLE, rv);
		check("angle", rv, {2'h0, angle_i});
		for (int p = 0; p < 16; p++) begin
			xwr(X_CFG, 32'(p));
			repeat (3) begin
				angle_i <= 14'($random(seed));
				cyc(3);
				check("commutation", uvw_o, phase_of(angle_i, 4'(p)));
			end
		end
		lock_i <= 1'b1;
		xwr(X_HYS, 32'h0000_a000);
		lock_i <= 1'b0;
		xwr(X_CFG, 32'h0000_1000);
		xrd(X_HYS, xv);
		check("locked write", xv, xo);
		xwr(X_HYS, 32'h0000_a000);
		angle_i <= 14'h0800;
		selftest();
		foreach (cs[i]) hstep(14'(2048 + cs[i]));
		repeat (40) hstep(angle_i + 14'($random(seed) % 20));
		hstep(angle_i - 14'd30);
		selftest();
		hstep(angle_i - 14'd6);
		drd(A_STAT, rv);
		check("self-test dir", rv[0], 1'b0);
		wreg(H_CFG, 16'h0001);
		xwr(X_OPT, 32'h0000_0004);
		xrd(X_OPT, xv);
		check("ignored", rv[1], 1'b1);
		wreg(H_CFG, 16'h0000);
		xrd(X_OPT, xv);
		check("other link", xv, 32'h0000_0004);
		step45 = 1'b0;
		xwr(X_OPT, 32'h0000_0000);
		go(2'h1);
		tc = 12'h000;
		tw = 1'b0;
		omove(2052, 1'b1);
		omove(5, 1'b0);
		lock_i <= 1'b1;
		go(2'h1);
		lock_i <= 1'b0;
		omove(1, 1'b1);
		go(2'h1);
		tc = 12'h000;
		tw = 1'b0;
		step45 = 1'b1;
		xwr(X_OPT, 32'h0000_0008);
		omove(3, 1'b1);
		omove(2055, 1'b0);
		// Single write path: turns reset through control
		wreg(H_ADDR, {7'h00, 1'b1, A_CTRL});
		wreg(H_WDATA, 16'h5a31);
		go(2'h0);
		tc = 12'h000;
		tw = 1'b0;
		omove(0, 1'b1);
		drd(A_CTRL, rv);
		check("control", rv, 16'h5a30);
		results();
	end
endmodule
`default_nettype wire
